/* src/fspc_consts.vh */
// constants of the flash self-programming controller
`ifndef FSPC_CONSTS_VH
`define FSPC_CONSTS_VH
`define FSPC_REG_DATA_ADDR 16'h0057
`define FSPC_IO_OFFSET 16'h0020
`define FSPC_REG_RESET 8'h00
`define FSPC_BIT_IE 7
`define FSPC_BIT_BUSY 6
`define FSPC_BIT_SIG 5
`define FSPC_BIT_REEN 4
`define FSPC_BIT_LOCK 3
`define FSPC_BIT_PGWR 2
`define FSPC_BIT_PGER 1
`define FSPC_BIT_STORE_ENABLE 0
`define FSPC_CMD_FILL 5'h01
`define FSPC_CMD_ERASE 5'h03
`define FSPC_CMD_WRITE 5'h05
`define FSPC_CMD_LOCK 5'h09
`define FSPC_CMD_REEN 5'h11
`define FSPC_STORE_WIN 3'h4
`define FSPC_LOAD_WIN 3'h3
`define FSPC_HALT_BASE 14'h3800
`define FSPC_BOOT_256 14'h3F00
`define FSPC_BOOT_512 14'h3E00
`define FSPC_BOOT_1K 14'h3C00
`define FSPC_BOOT_2K 14'h3800
`define FSPC_PROG_TIME_US 4000
`define FSPC_CLK_MHZ 40
`define FSPC_PROG_CYCLES (`FSPC_PROG_TIME_US * `FSPC_CLK_MHZ)
`endif

/* src/fspc_cmd_window.v */
// store/load acceptance window counter
`include "fspc_consts.vh"
module fspc_cmd_window (
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire start_in,
  input wire stop_in,
  output reg [2:0] age_out,
  output reg open_out
);
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      age_out <= 3'h0;
      open_out <= 1'b0;
    end else if (ce_in) begin
      if (start_in) begin
        age_out <= 3'h0;
        open_out <= 1'b1;
      end else if (stop_in) begin
        open_out <= 1'b0;
      end else if (open_out) begin
        age_out <= age_out + 3'h1;
        // lapses after four cycles unused
        if (age_out == `FSPC_STORE_WIN - 3'h1) begin
          open_out <= 1'b0;
        end
      end
    end
  end
endmodule // fspc_cmd_window

/* src/fspc_prog_timer.v */
// programming duration timer for erase, write and lock operations
`include "fspc_consts.vh"
module fspc_prog_timer #(
  parameter CYCLES = `FSPC_PROG_CYCLES
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire start_in,
  output reg busy_out,
  output reg done_out
);
  reg [31:0] count;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= 32'h0000_0000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        count <= CYCLES - 1;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (count == 32'h0000_0000) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count <= count - 32'h0000_0001;
        end
      end
    end
  end
endmodule // fspc_prog_timer

/* src/fspc_ctrl.v */
// flash self-programming controller top
`include "fspc_consts.vh"
module fspc_ctrl #(
  parameter PROG_CYCLES = `FSPC_PROG_CYCLES
) (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire ce_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire io_space_in,
  input wire [15:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire store_instr_in,
  input wire load_instr_in,
  input wire [15:0] zptr_in,
  input wire [7:0] r0_in,
  input wire [7:0] r1_in,
  input wire global_irq_flag_in,
  input wire eeprom_write_active_in,
  input wire [1:0] boot_size_select_in,
  input wire [7:0] lock_bits_in,
  input wire [7:0] fuse_low_in,
  input wire [7:0] fuse_high_in,
  input wire [7:0] fuse_ext_in,
  input wire [7:0] sig_byte_in,
  input wire [13:0] fetch_addr_in,
  output reg [7:0] reg_rdata_out,
  output reg [7:0] load_data_out,
  output reg load_data_valid_out,
  output reg [4:0] sig_addr_out,
  output reg buf_wr_out,
  output reg [5:0] buf_word_out,
  output reg [15:0] buf_data_out,
  output reg buf_clear_out,
  output reg flash_erase_out,
  output reg flash_write_out,
  output reg [7:0] flash_page_out,
  output reg lock_write_out,
  output reg [7:0] lock_data_out,
  output reg cpu_halt_out,
  output reg concurrent_read_block_out,
  output reg store_ready_irq_out,
  output reg [13:0] boot_start_out,
  output reg fetch_in_boot_out
);
  ////////////////////////////////////////////////////////////////////////////
  // reset synchroniser
  reg rst_s1;
  reg rst_n;
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state and address decode
  reg store_ready_irq_enable;
  reg concurrent_section_busy;
  reg [4:0] cmd;
  reg prog_target_halting;
  reg fill_active;
  reg sig_window;

  wire [2:0] win_age;
  wire win_open;
  wire prog_busy;
  wire prog_done;

  wire [15:0] eff_addr = io_space_in ?
    reg_addr_in + `FSPC_IO_OFFSET : reg_addr_in;
  wire reg_hit = (eff_addr == `FSPC_REG_DATA_ADDR) &&
    (!io_space_in || reg_addr_in < 16'h0040);
  wire [4:0] wr_cmd = reg_wdata_in[4:0];

  function is_valid_cmd;
    input [4:0] c;
    begin
      is_valid_cmd = (c == `FSPC_CMD_FILL) || (c == `FSPC_CMD_ERASE) ||
        (c == `FSPC_CMD_WRITE) || (c == `FSPC_CMD_LOCK) ||
        (c == `FSPC_CMD_REEN);
    end
  endfunction

  // a new command is accepted only while no store is pending or busy
  wire cmd_wr = reg_wr_in && reg_hit && !prog_busy &&
    !cmd[`FSPC_BIT_STORE_ENABLE] && (is_valid_cmd(wr_cmd) ||
    (reg_wdata_in[`FSPC_BIT_SIG] && wr_cmd == `FSPC_CMD_FILL));
  wire sig_cmd = reg_wdata_in[`FSPC_BIT_SIG] && wr_cmd == `FSPC_CMD_FILL;
  wire reen_during_fill = reg_wr_in && reg_hit &&
    reg_wdata_in[`FSPC_BIT_REEN] && fill_active;

  wire store_go = store_instr_in && win_open && !prog_busy;
  wire load_go = load_instr_in && win_open && !prog_busy &&
    win_age < `FSPC_LOAD_WIN;
  wire [7:0] zpage = zptr_in[14:7];
  wire [5:0] zword = zptr_in[6:1];
  wire ztarget_halting = {zpage, 6'h00} >= `FSPC_HALT_BASE;
  wire is_erase = cmd == `FSPC_CMD_ERASE;
  wire is_write = cmd == `FSPC_CMD_WRITE;
  wire start_prog = store_go && !sig_window &&
    (is_erase || is_write || cmd == `FSPC_CMD_LOCK);

  fspc_cmd_window u_win (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .start_in(cmd_wr),
    .stop_in(store_go || load_go),
    .age_out(win_age),
    .open_out(win_open)
  );

  fspc_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .start_in(start_prog),
    .busy_out(prog_busy),
    .done_out(prog_done)
  );

  function [13:0] boot_base;
    input [1:0] sz;
    begin
      case (sz)
        2'b11: boot_base = `FSPC_BOOT_256;
        2'b10: boot_base = `FSPC_BOOT_512;
        2'b01: boot_base = `FSPC_BOOT_1K;
        default: boot_base = `FSPC_BOOT_2K;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // control state
  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      store_ready_irq_enable <= 1'b0;
      concurrent_section_busy <= 1'b0;
      cmd <= 5'h00;
      prog_target_halting <= 1'b0;
      fill_active <= 1'b0;
      sig_window <= 1'b0;
    end else if (ce_in) begin
      if (reg_wr_in && reg_hit) begin
        store_ready_irq_enable <= reg_wdata_in[`FSPC_BIT_IE];
      end
      if (cmd_wr) begin
        cmd <= wr_cmd;
        sig_window <= sig_cmd;
      end else if (prog_busy) begin
        // held high until the operation ends
        if (prog_done) begin
          cmd <= 5'h00;
        end
      end else if (prog_done) begin
        cmd <= 5'h00;
      end else if (start_prog) begin
        prog_target_halting <= ztarget_halting && cmd != `FSPC_CMD_LOCK;
      end else if (store_go || load_go || (!win_open && cmd != 5'h00)) begin
        cmd <= 5'h00;
        sig_window <= 1'b0;
      end
      if (start_prog) begin
        prog_target_halting <= ztarget_halting && cmd != `FSPC_CMD_LOCK;
      end
      // set wins over clear in the same cycle
      if (start_prog && (is_erase || is_write) && !ztarget_halting) begin
        concurrent_section_busy <= 1'b1;
      end else if (store_go && cmd == `FSPC_CMD_REEN && !prog_busy) begin
        concurrent_section_busy <= 1'b0;
      end else if (store_go && cmd == `FSPC_CMD_FILL && !sig_window) begin
        concurrent_section_busy <= 1'b0;
      end
      if (reen_during_fill) begin
        fill_active <= 1'b0;
      end else if (store_go && cmd == `FSPC_CMD_FILL && !sig_window) begin
        fill_active <= 1'b1;
      end else if (start_prog && is_write) begin
        fill_active <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= `FSPC_REG_RESET;
      load_data_out <= 8'h00;
      load_data_valid_out <= 1'b0;
      sig_addr_out <= 5'h00;
      buf_wr_out <= 1'b0;
      buf_word_out <= 6'h00;
      buf_data_out <= 16'h0000;
      buf_clear_out <= 1'b0;
      flash_erase_out <= 1'b0;
      flash_write_out <= 1'b0;
      flash_page_out <= 8'h00;
      lock_write_out <= 1'b0;
      lock_data_out <= 8'hFF;
      cpu_halt_out <= 1'b0;
      concurrent_read_block_out <= 1'b0;
      store_ready_irq_out <= 1'b0;
      boot_start_out <= `FSPC_BOOT_2K;
      fetch_in_boot_out <= 1'b0;
    end else if (ce_in) begin
      reg_rdata_out <= (reg_rd_in && reg_hit) ? {store_ready_irq_enable,
        concurrent_section_busy, sig_window, cmd} : 8'h00;
      load_data_valid_out <= 1'b0;
      buf_wr_out <= 1'b0;
      buf_clear_out <= reen_during_fill;
      flash_erase_out <= 1'b0;
      flash_write_out <= 1'b0;
      lock_write_out <= 1'b0;
      if (load_go && sig_window) begin
        sig_addr_out <= zptr_in[4:0];
        load_data_out <= sig_byte_in;
        load_data_valid_out <= 1'b1;
      end else if (load_go && cmd == `FSPC_CMD_LOCK) begin
        // programmed bits come back as zero
        case (zptr_in[1:0])
          2'b00: load_data_out <= fuse_low_in;
          2'b01: load_data_out <= lock_bits_in;
          2'b10: load_data_out <= fuse_ext_in;
          default: load_data_out <= fuse_high_in;
        endcase
        load_data_valid_out <= 1'b1;
      end
      if (store_go && !sig_window && cmd == `FSPC_CMD_FILL) begin
        buf_wr_out <= 1'b1;
        buf_word_out <= zword;
        buf_data_out <= {r1_in, r0_in};
      end
      if (start_prog) begin
        flash_page_out <= zpage;
        flash_erase_out <= is_erase;
        flash_write_out <= is_write;
        lock_write_out <= cmd == `FSPC_CMD_LOCK;
        lock_data_out <= r0_in;
      end
      cpu_halt_out <= (start_prog && ztarget_halting &&
        (is_erase || is_write)) || (prog_busy && !prog_done &&
        prog_target_halting);
      concurrent_read_block_out <= concurrent_section_busy;
      store_ready_irq_out <= store_ready_irq_enable && global_irq_flag_in &&
        !cmd[`FSPC_BIT_STORE_ENABLE];
      boot_start_out <= boot_base(boot_size_select_in);
      fetch_in_boot_out <= fetch_addr_in >= boot_base(boot_size_select_in);
    end
  end
endmodule // fspc_ctrl

/* tb/fspc_checker.sv */
// port assertions for the flash self-programming controller
module fspc_checker (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire reg_rd_in,
  input wire io_space_in,
  input wire [15:0] reg_addr_in,
  input wire [15:0] zptr_in,
  input wire [7:0] r0_in,
  input wire [7:0] r1_in,
  input wire load_instr_in,
  input wire [1:0] boot_size_select_in,
  input wire [7:0] reg_rdata_out,
  input wire load_data_valid_out,
  input wire buf_wr_out,
  input wire [5:0] buf_word_out,
  input wire [15:0] buf_data_out,
  input wire flash_erase_out,
  input wire flash_write_out,
  input wire [7:0] flash_page_out,
  input wire lock_write_out,
  input wire [7:0] lock_data_out,
  input wire cpu_halt_out,
  input wire concurrent_read_block_out,
  input wire [13:0] boot_start_out
);
  wire flash_op = flash_erase_out | flash_write_out;
  // pages from 0xE0 up sit in the halting section
  wire hi_page = flash_page_out >= 8'hE0;
  wire [1:0] bs = boot_size_select_in;
  wire [13:0] boot_exp = bs[1] ? (bs[0] ? 14'h3F00 : 14'h3E00) :
    (bs[0] ? 14'h3C00 : 14'h3800);
  wire [15:0] hit = io_space_in ? 16'h0057 - 16'h0020 : 16'h0057;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  //////////////////////////////
  a_boot_start_map: assert property (
    $stable(bs) [*6] |-> boot_start_out == boot_exp) else $error("boot");
  a_buf_word_data: assert property (
    buf_wr_out |-> buf_word_out == $past(zptr_in[6:1])
    && buf_data_out == $past({r1_in, r0_in})) else $error("fill");
  a_flash_page_field: assert property (
    flash_op |-> flash_page_out == $past(zptr_in[14:7])) else $error("page");
  a_lock_from_r0: assert property (
    lock_write_out |-> lock_data_out == $past(r0_in)) else $error("lock");
  a_halt_only_high: assert property (
    cpu_halt_out |-> hi_page) else $error("halt");
  a_block_low_pages: assert property (
    flash_op && !hi_page |-> ##[0:2] concurrent_read_block_out)
    else $error("busy");
  a_unmapped_read: assert property (
    reg_rd_in && reg_addr_in != hit |=> reg_rdata_out == 8'h00)
    else $error("decode");
  a_load_has_cause: assert property (
    load_data_valid_out |-> $past(load_instr_in)) else $error("load");
  c_high_write: cover property (flash_write_out && hi_page);
  c_lock_write: cover property (lock_write_out);
  c_load_seen: cover property (load_data_valid_out);
endmodule // fspc_checker
bind fspc_ctrl fspc_checker i_fspc_checker (.*);

/* tb/fspc_cpu_model.sv */
// behavioural cpu core issuing store and load program-memory instructions
module fspc_cpu_model (
  input wire clk_in,
  output logic store_out = 0,
  output logic load_out = 0,
  output logic [15:0] zptr_out = 0,
  output logic [7:0] r0_out = 0,
  output logic [7:0] r1_out = 0
);
  timeunit 1ns;
  timeprecision 100ps;
  // operands are junk once the instruction is gone
  task automatic spm(input logic [15:0] z, input logic [7:0] lo, hi,
    input int gap = 0);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    store_out <= 1;
    zptr_out <= {z[15:1], 1'b0};
    r0_out <= lo;
    r1_out <= hi;
    @(posedge clk_in);
    store_out <= 0;
    zptr_out <= ~zptr_out;
    r0_out <= ~r0_out;
    r1_out <= ~r1_out;
  endtask
  task automatic lpm(input logic [15:0] z);
    @(posedge clk_in);
    load_out <= 1;
    zptr_out <= z;
    @(posedge clk_in);
    load_out <= 0;
    zptr_out <= ~zptr_out;
  endtask
endmodule // fspc_cpu_model

/* tb/tb_top.sv */
// self-checking bench for the flash self-programming controller
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_in = 0, arst_n_in = 0, ce_in = 1, reg_wr_in = 0;
  logic reg_rd_in = 0, io_space_in = 0, global_irq_flag_in = 0;
  logic eeprom_write_active_in = 0;
  logic [15:0] reg_addr_in = 0;
  logic [7:0] reg_wdata_in = 0, lock_bits_in = 8'hA5, fuse_low_in = 8'h3C;
  logic [7:0] fuse_high_in = 8'h5A, fuse_ext_in = 8'hF1, sig_byte_in = 8'h96;
  logic [1:0] boot_size_select_in = 0;
  logic [13:0] fetch_addr_in = 0;
  wire store_instr_in, load_instr_in, load_data_valid_out, buf_wr_out;
  wire buf_clear_out, flash_erase_out, flash_write_out, lock_write_out;
  wire cpu_halt_out, concurrent_read_block_out, store_ready_irq_out;
  wire fetch_in_boot_out;
  wire [15:0] zptr_in, buf_data_out;
  wire [7:0] r0_in, r1_in, reg_rdata_out, load_data_out, flash_page_out;
  wire [7:0] lock_data_out;
  wire [5:0] buf_word_out;
  wire [4:0] sig_addr_out;
  wire [13:0] boot_start_out;
  int n_errors = 0, check_count = 0, n = 0;
  logic [7:0] d;
  // short programming time keeps the run brief
  fspc_ctrl #(.PROG_CYCLES(20)) i_fspc_ctrl (.*);
  fspc_cpu_model i_fspc_cpu_model (.clk_in(sys_clk_in),
    .store_out(store_instr_in), .load_out(load_instr_in),
    .zptr_out(zptr_in), .r0_out(r0_in), .r1_out(r1_in));
  always #12.5 sys_clk_in = ~sys_clk_in;
  //////////////////////////////
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] v, input logic iosp = 0);
    @(posedge sys_clk_in);
    reg_wr_in <= 1;
    io_space_in <= iosp;
    reg_addr_in <= iosp ? 16'h0037 : 16'h0057;
    reg_wdata_in <= v;
    @(posedge sys_clk_in);
    reg_wr_in <= 0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk_in);
    reg_rd_in <= 1;
    io_space_in <= 0;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 0;
    #1 d = reg_rdata_out;
  endtask
  // polls until the store enable drops or 40 reads pass, counting reads
  task automatic wait_idle;
    n = 0;
    do begin
      rd(16'h0057);
      n++;
    end while (d[0] !== 0 && n < 40);
  endtask
  //////////////////////////////
  task automatic t_boot;
    for (int c = 0; c < 4; c++) begin
      @(posedge sys_clk_in);
      boot_size_select_in <= c[1:0];
      fetch_addr_in <= 14'h3900;
      repeat (8) @(posedge sys_clk_in);
      chk(boot_start_out, 16'h4000 - (16'h0800 >> c));
      chk(fetch_in_boot_out, c == 0);
    end
  endtask
  task automatic t_regs;
    rd(16'h0057);
    chk(d, 8'h00);
    wr(8'h80, 1);
    rd(16'h0057);
    chk(d, 8'h80);
    rd(16'h0037);
    chk(d, 8'h00);
    wr(8'h87);
    rd(16'h0057);
    chk(d, 8'h80);
    @(posedge sys_clk_in);
    global_irq_flag_in <= 1;
    repeat (3) @(posedge sys_clk_in);
    #1 chk(store_ready_irq_out, 1);
  endtask
  task automatic t_fill;
    wr(8'h81);
    i_fspc_cpu_model.spm(16'h808A, 8'h34, 8'h12);
    #1 chk({buf_wr_out, buf_word_out}, 7'h45);
    chk(buf_data_out, 16'h1234);
    rd(16'h0057);
    chk(d, 8'h80);
    wr(8'h81);
    i_fspc_cpu_model.spm(16'h0002, 8'h01, 8'h02, 6);
    #1 chk(buf_wr_out, 0);
  endtask
  task automatic t_erase;
    wr(8'h83);
    i_fspc_cpu_model.spm(16'h0800, 8'h00, 8'h00);
    #1 chk({flash_erase_out, flash_page_out}, 9'h110);
    rd(16'h0057);
    chk(d, 8'hC3);
    chk({cpu_halt_out, store_ready_irq_out}, 0);
    chk(concurrent_read_block_out, 1);
    wait_idle;
    chk(d, 8'hC0);
    chk(n >= 5, 1);
    wr(8'h91);
    #1 chk(buf_clear_out, 1);
    i_fspc_cpu_model.spm(16'h0000, 8'h00, 8'h00);
    rd(16'h0057);
    chk({d, concurrent_read_block_out}, 9'h100);
  endtask
  task automatic t_write;
    wr(8'h85);
    i_fspc_cpu_model.spm(16'h7000, 8'h00, 8'h00);
    #1 chk({flash_write_out, flash_page_out}, 9'h1E0);
    @(posedge sys_clk_in);
    #1 chk(cpu_halt_out, 1);
    wait_idle;
    chk({d, cpu_halt_out}, 9'h100);
  endtask
  task automatic t_lock;
    logic [7:0] e [4] = '{fuse_low_in, lock_bits_in, fuse_ext_in,
      fuse_high_in};
    wr(8'h89);
    i_fspc_cpu_model.spm(16'hFFFF, 8'hC3, 8'h77);
    #1 chk({lock_write_out, lock_data_out}, 9'h1C3);
    wait_idle;
    chk(d, 8'h80);
    for (int k = 0; k < 4; k++) begin
      wr(8'h89);
      i_fspc_cpu_model.lpm(k[15:0]);
      #1 chk({load_data_valid_out, load_data_out}, {1'b1, e[k]});
      repeat (5) @(posedge sys_clk_in);
    end
    wr(8'hA1);
    i_fspc_cpu_model.lpm(16'h0004);
    #1 chk({load_data_valid_out, load_data_out}, 9'h196);
    chk(sig_addr_out, 5'h04);
    wr(8'hA1);
    i_fspc_cpu_model.spm(16'h0000, 8'h00, 8'h00);
    #1 chk(buf_wr_out, 0);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk_in);
    arst_n_in <= 1;
    repeat (3) @(posedge sys_clk_in);
    t_boot;
    t_regs;
    t_fill;
    t_erase;
    t_write;
    t_lock;
    print_verdict;
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    print_verdict;
  end
endmodule // tb_top
